// file: hdl/canopen_led_pkg.sv
package canopen_led_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W          = 4;
    localparam int unsigned DATA_W          = 32;
    localparam int unsigned BE_W            = DATA_W / 8;
    localparam logic [3:0]  CTRL_OFS        = 4'h0;
    localparam logic [3:0]  STATUS_OFS      = 4'h4;
    localparam logic [3:0]  PHASE_OFS       = 4'h8;
    localparam logic [3:0]  TIMEBASE_OFS    = 4'hC;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_STATE_LSB  = 0;
    localparam int unsigned NODE_W          = 2;
    localparam int unsigned CTRL_WARN_BIT   = 4;
    localparam int unsigned CTRL_ECEV_BIT   = 5;
    localparam int unsigned CTRL_BOFF_BIT   = 6;
    localparam int unsigned CTRL_DUAL_BIT   = 8;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK      = 32'h0000_0173;

    // ------------------------------------------------------------------
    // Node state codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  node_reset_state   = 2'h0;
    localparam logic [1:0]  node_running_state = 2'h1;
    localparam logic [1:0]  node_setup_state   = 2'h2;
    localparam logic [1:0]  node_halted_state  = 2'h3;

    // ------------------------------------------------------------------
    // Status and phase fields
    // ------------------------------------------------------------------
    localparam int unsigned PAT_W            = 3;
    localparam int unsigned STAT_GPAT_LSB    = 0;
    localparam int unsigned STAT_RPAT_LSB    = 4;
    localparam int unsigned STAT_GLIT_BIT    = 8;
    localparam int unsigned STAT_RLIT_BIT    = 9;
    localparam int unsigned STAT_DUAL_BIT    = 10;
    localparam int unsigned PHASE_G_LSB      = 0;
    localparam int unsigned PHASE_R_LSB      = 16;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned MS_PER_S        = 1000;
    localparam int unsigned MS_CYCLES_DEF   = CLK_HZ / MS_PER_S;
    localparam int unsigned MS_W            = 11;
    localparam int unsigned FLASH_ON_MS     = 200;
    localparam int unsigned BLINK_OFF_MS    = 200;
    localparam int unsigned GAP_OFF_MS      = 200;
    localparam int unsigned LONG_OFF_MS     = 1000;
    localparam int unsigned BLINK_PERIOD_MS  = FLASH_ON_MS + BLINK_OFF_MS;
    localparam int unsigned SINGLE_PERIOD_MS = FLASH_ON_MS + LONG_OFF_MS;
    localparam int unsigned SECOND_ON_MS     = FLASH_ON_MS + GAP_OFF_MS;
    localparam int unsigned SECOND_OFF_MS    = SECOND_ON_MS + FLASH_ON_MS;
    localparam int unsigned DOUBLE_PERIOD_MS = SECOND_OFF_MS + LONG_OFF_MS;

    // ------------------------------------------------------------------
    // Indicator patterns
    // ------------------------------------------------------------------
    typedef enum logic [PAT_W-1:0] {
        PAT_OFF,
        PAT_STEADY,
        PAT_BLINK,
        PAT_SINGLE,
        PAT_DOUBLE
    } pattern_t;

endpackage : canopen_led_pkg

// file: hdl/canopen_status_led_driver.sv
`timescale 1ns/10ps
// Summary of operation
// - Node running state lights green steadily.
// - Node setup state blinks green at 2.5 Hz.
// - Node halted state shows green single flash.
// - Error counter at or past warning level shows red single flash.
// - Error control event (guarding or heartbeat) shows red double flash.
// - Bus off lights red steadily.
// - Reset or missing configuration keeps the indicator dark.
// - Blink is 200 ms lit, 200 ms dark, repeating.
// - Single flash is 200 ms lit, 1000 ms dark, repeating.
// - Double flash is 200 lit, 200 dark, 200 lit, 1000 dark.
// - Two-indicator mode: red dark without error, green alone shows state.
// - Two-indicator mode: red error meaning stands regardless of dark green.
// - Two indicators for detached interface or older boards, else one bi-colour.
module canopen_status_led_driver #(
    parameter int unsigned MS_CYCLES = canopen_led_pkg::MS_CYCLES_DEF  // Clocks per millisecond
) (
    input  wire logic        mclk,         // System clock, 200 MHz
    input  wire logic        sys_rst,      // Asynchronous reset, active high
    input  wire logic [3:0]  address,      // Avalon byte address
    input  wire logic        read,         // Avalon read request
    input  wire logic        write,        // Avalon write request
    input  wire logic [31:0] writedata,    // Avalon write data
    input  wire logic [3:0]  byteenable,   // Avalon byte lanes
    output logic      [31:0] readdata,     // Avalon read data
    output logic             waitrequest,  // Avalon stall, low completes
    output logic             led_green,    // Green indicator, high lit
    output logic             led_red       // Red indicator, high lit
);

    // ------------------------------------------------------------------
    // Local types and constants
    // ------------------------------------------------------------------
    localparam int unsigned NCH   = 2;
    localparam int unsigned CH_G  = 0;
    localparam int unsigned CH_R  = 1;
    localparam int unsigned PRE_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

    localparam logic [canopen_led_pkg::MS_W-1:0] ON_END_MS =
        canopen_led_pkg::MS_W'(canopen_led_pkg::FLASH_ON_MS);
    localparam logic [canopen_led_pkg::MS_W-1:0] SECOND_ON_MS =
        canopen_led_pkg::MS_W'(canopen_led_pkg::SECOND_ON_MS);
    localparam logic [canopen_led_pkg::MS_W-1:0] SECOND_OFF_MS =
        canopen_led_pkg::MS_W'(canopen_led_pkg::SECOND_OFF_MS);

    typedef logic [canopen_led_pkg::MS_W-1:0] ms_t;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic addr_is(input logic [3:0] addr, input logic [3:0] ofs);
        return addr == ofs;
    endfunction : addr_is

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < canopen_led_pkg::BE_W; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // Last millisecond index of one pattern cycle
    function automatic ms_t pattern_last(input canopen_led_pkg::pattern_t p);
        ms_t last;
        last = '0;
        case (p)
            canopen_led_pkg::PAT_BLINK: begin
                last = canopen_led_pkg::MS_W'(canopen_led_pkg::BLINK_PERIOD_MS - 1);
            end
            canopen_led_pkg::PAT_SINGLE: begin
                last = canopen_led_pkg::MS_W'(canopen_led_pkg::SINGLE_PERIOD_MS - 1);
            end
            canopen_led_pkg::PAT_DOUBLE: begin
                last = canopen_led_pkg::MS_W'(canopen_led_pkg::DOUBLE_PERIOD_MS - 1);
            end
            default: begin
                last = '0;
            end
        endcase
        return last;
    endfunction : pattern_last

    // Lit or dark at a given millisecond of the pattern cycle
    function automatic logic pattern_lit(input canopen_led_pkg::pattern_t p, input ms_t ms);
        logic lit;
        lit = 1'b0;
        case (p)
            canopen_led_pkg::PAT_STEADY: begin
                lit = 1'b1;
            end
            canopen_led_pkg::PAT_BLINK, canopen_led_pkg::PAT_SINGLE: begin
                lit = ms < ON_END_MS;
            end
            canopen_led_pkg::PAT_DOUBLE: begin
                lit = (ms < ON_END_MS) || ((ms >= SECOND_ON_MS) && (ms < SECOND_OFF_MS));
            end
            default: begin
                lit = 1'b0;
            end
        endcase
        return lit;
    endfunction : pattern_lit

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [31:0]               ctrl_r;
    logic                      waitreq_r;
    logic [31:0]               rdata_r;
    canopen_led_pkg::pattern_t pat_r   [NCH];
    logic [PRE_W-1:0]          pre_r   [NCH];
    ms_t                       phase_r [NCH];
    logic [NCH-1:0]            led_r;

    logic                      req;
    logic                      accept;
    logic [1:0]                node_state;
    logic                      dual_mode;
    canopen_led_pkg::pattern_t green_nxt;
    canopen_led_pkg::pattern_t red_nxt;
    canopen_led_pkg::pattern_t sel_nxt [NCH];
    logic [31:0]               read_nxt;

    assign req         = read || write;
    assign accept      = req && !waitreq_r;
    assign node_state  = ctrl_r[canopen_led_pkg::CTRL_STATE_LSB +: canopen_led_pkg::NODE_W];
    assign dual_mode   = ctrl_r[canopen_led_pkg::CTRL_DUAL_BIT];

    assign readdata    = rdata_r;
    assign waitrequest = waitreq_r;
    assign led_green   = led_r[CH_G];
    assign led_red     = led_r[CH_R];

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // Stall by default, release for one cycle after a request is seen
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            waitreq_r <= 1'b1;
        end else if (req && waitreq_r) begin
            waitreq_r <= 1'b0;
        end else begin
            waitreq_r <= 1'b1;
        end
    end

    always_comb begin
        read_nxt = '0;
        if (addr_is(address, canopen_led_pkg::CTRL_OFS)) begin
            read_nxt = ctrl_r;
        end else if (addr_is(address, canopen_led_pkg::STATUS_OFS)) begin
            read_nxt[canopen_led_pkg::STAT_GPAT_LSB +: canopen_led_pkg::PAT_W] = pat_r[CH_G];
            read_nxt[canopen_led_pkg::STAT_RPAT_LSB +: canopen_led_pkg::PAT_W] = pat_r[CH_R];
            read_nxt[canopen_led_pkg::STAT_GLIT_BIT] = led_r[CH_G];
            read_nxt[canopen_led_pkg::STAT_RLIT_BIT] = led_r[CH_R];
            read_nxt[canopen_led_pkg::STAT_DUAL_BIT] = dual_mode;
        end else if (addr_is(address, canopen_led_pkg::PHASE_OFS)) begin
            read_nxt[canopen_led_pkg::PHASE_G_LSB +: canopen_led_pkg::MS_W] = phase_r[CH_G];
            read_nxt[canopen_led_pkg::PHASE_R_LSB +: canopen_led_pkg::MS_W] = phase_r[CH_R];
        end else if (addr_is(address, canopen_led_pkg::TIMEBASE_OFS)) begin
            read_nxt = 32'(MS_CYCLES);
        end
    end

    // Read data captured as the stall drops, held until the next read
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (read && waitreq_r) begin
            rdata_r <= read_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= canopen_led_pkg::CTRL_RESET;
        end else if (accept && write && addr_is(address, canopen_led_pkg::CTRL_OFS)) begin
            ctrl_r <= lane_merge(ctrl_r, writedata, byteenable) & canopen_led_pkg::CTRL_WMASK;
        end
    end

    // ------------------------------------------------------------------
    // Pattern selection
    // ------------------------------------------------------------------
    always_comb begin
        case (node_state)
            canopen_led_pkg::node_running_state: begin
                green_nxt = canopen_led_pkg::PAT_STEADY;
            end
            canopen_led_pkg::node_setup_state: begin
                green_nxt = canopen_led_pkg::PAT_BLINK;
            end
            canopen_led_pkg::node_halted_state: begin
                green_nxt = canopen_led_pkg::PAT_SINGLE;
            end
            default: begin
                green_nxt = canopen_led_pkg::PAT_OFF;
            end
        endcase
    end

    // Most severe error condition chosen first
    always_comb begin
        if (ctrl_r[canopen_led_pkg::CTRL_BOFF_BIT]) begin
            red_nxt = canopen_led_pkg::PAT_STEADY;
        end else if (ctrl_r[canopen_led_pkg::CTRL_ECEV_BIT]) begin
            red_nxt = canopen_led_pkg::PAT_DOUBLE;
        end else if (ctrl_r[canopen_led_pkg::CTRL_WARN_BIT]) begin
            red_nxt = canopen_led_pkg::PAT_SINGLE;
        end else begin
            red_nxt = canopen_led_pkg::PAT_OFF;
        end
    end

    // Bi-colour lamp shows one colour; red hides green there
    always_comb begin
        sel_nxt[CH_R] = red_nxt;
        if (!dual_mode && (red_nxt != canopen_led_pkg::PAT_OFF)) begin
            sel_nxt[CH_G] = canopen_led_pkg::PAT_OFF;
        end else begin
            sel_nxt[CH_G] = green_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Selected pattern memory
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NCH; i++) begin
                pat_r[i] <= canopen_led_pkg::PAT_OFF;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                pat_r[i] <= sel_nxt[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Millisecond prescalers
    // ------------------------------------------------------------------
    // One per channel so a restart begins on a full millisecond
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NCH; i++) begin
                pre_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if ((sel_nxt[i] != pat_r[i]) || (pre_r[i] == PRE_LAST)) begin
                    pre_r[i] <= '0;
                end else begin
                    pre_r[i] <= pre_r[i] + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Pattern phase counters
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NCH; i++) begin
                phase_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (sel_nxt[i] != pat_r[i]) begin
                    phase_r[i] <= '0;
                end else if (pre_r[i] == PRE_LAST) begin
                    if (phase_r[i] >= pattern_last(pat_r[i])) begin
                        phase_r[i] <= '0;
                    end else begin
                        phase_r[i] <= phase_r[i] + 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Indicator outputs
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            led_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                led_r[i] <= pattern_lit(pat_r[i], phase_r[i]);
            end
        end
    end

endmodule : canopen_status_led_driver

// file: verification/canopen_led_props.sv
`timescale 1ns/10ps
module canopen_led_props #(
    parameter int unsigned MS_CYCLES = canopen_led_pkg::MS_CYCLES_DEF  // Clocks per ms
) (
    input wire logic        mclk,         // System clock
    input wire logic        sys_rst,      // Reset, active high
    input wire logic [3:0]  address,      // Bus address
    input wire logic        read,         // Bus read
    input wire logic        write,        // Bus write
    input wire logic [31:0] writedata,    // Bus write data
    input wire logic [3:0]  byteenable,   // Bus byte lanes
    input wire logic [31:0] readdata,     // Bus read data
    input wire logic        waitrequest,  // Bus stall
    input wire logic        led_green,    // Green indicator
    input wire logic        led_red       // Red indicator
);
    localparam logic [15:0] ON_C = 16'(canopen_led_pkg::FLASH_ON_MS * MS_CYCLES);
    localparam logic [15:0] GAP_C = 16'(canopen_led_pkg::GAP_OFF_MS * MS_CYCLES);
    localparam logic [15:0] BLK_C = 16'(canopen_led_pkg::BLINK_OFF_MS * MS_CYCLES);
    localparam logic [15:0] LONG_C = 16'(canopen_led_pkg::LONG_OFF_MS * MS_CYCLES);
    logic [8:0]  sh_r;
    logic [15:0] quiet_r, g_run_r, r_run_r;
    logic        g_prev_r, r_prev_r;
    wire logic   ctrl_wr = write && !waitrequest && address == canopen_led_pkg::CTRL_OFS;
    wire logic   err = |sh_r[6:4];
    wire logic   flash_r = !sh_r[6] && |sh_r[5:4];
    wire logic   g_flash = sh_r[1] && (sh_r[8] || !err);
    wire logic   calm = quiet_r >= 16'h0003;
    // ------------------------
    // Shadow of control and run lengths
    // ------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_r <= 9'h000;
        end else if (ctrl_wr) begin
            if (byteenable[0]) sh_r[7:0] <= writedata[7:0] & 8'h73;
            if (byteenable[1]) sh_r[8] <= writedata[8];
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) quiet_r <= 16'h0000;
        else if (ctrl_wr) quiet_r <= 16'h0000;
        else if (quiet_r != 16'hFFFF) quiet_r <= quiet_r + 16'h0001;
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            g_prev_r <= 1'b0;
            r_prev_r <= 1'b0;
            g_run_r  <= 16'h0000;
            r_run_r  <= 16'h0000;
        end else begin
            g_prev_r <= led_green;
            r_prev_r <= led_red;
            g_run_r  <= (led_green != g_prev_r) ? 16'h0001 : g_run_r + 16'h0001;
            r_run_r  <= (led_red != r_prev_r) ? 16'h0001 : r_run_r + 16'h0001;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_one_wait; !waitrequest ##1 waitrequest; endsequence
    sequence s_g_fall; g_prev_r && !led_green && quiet_r >= g_run_r + 16'h0002; endsequence
    sequence s_g_rise; !g_prev_r && led_green && quiet_r >= g_run_r + 16'h0002; endsequence
    sequence s_r_fall; r_prev_r && !led_red && quiet_r >= r_run_r + 16'h0002; endsequence
    sequence s_r_rise; !r_prev_r && led_red && quiet_r >= r_run_r + 16'h0002; endsequence
    a_bus_answer: assert property ((read || write) && waitrequest |=> s_one_wait)
        else $error("Bus wait not one cycle");
    a_unmapped_zero: assert property (read && !waitrequest && address[1:0] != 2'h0
        |-> readdata == 32'h0000_0000) else $error("Unmapped not zero");
    a_timebase_value: assert property (read && !waitrequest && address == 4'hC
        |-> readdata == 32'(MS_CYCLES)) else $error("Timebase wrong");
    a_busoff_lit: assert property (calm && sh_r[6] |-> led_red)
        else $error("Bus off not red");
    a_reset_dark: assert property (calm && sh_r[1:0] == 2'h0 && !err |-> !led_green && !led_red)
        else $error("Reset not dark");
    a_running_lit: assert property (calm && sh_r[1:0] == 2'h1 && (sh_r[8] || !err) |-> led_green)
        else $error("Running not green");
    a_red_wins: assert property (calm && !sh_r[8] && err |-> !led_green)
        else $error("Green over red");
    a_red_quiet: assert property (calm && !err |-> !led_red)
        else $error("Red lit without error");
    a_green_lit_len: assert property (s_g_fall ##0 g_flash |-> g_run_r == ON_C)
        else $error("Green lit length");
    a_green_dark_len: assert property (s_g_rise ##0 g_flash
        |-> g_run_r == (sh_r[0] ? LONG_C : BLK_C))
        else $error("Green dark length");
    a_red_lit_len: assert property (s_r_fall ##0 flash_r |-> r_run_r == ON_C)
        else $error("Red lit length");
    a_red_dark_len: assert property (s_r_rise ##0 flash_r
        |-> r_run_r == LONG_C || sh_r[5] && r_run_r == GAP_C) else $error("Red dark length");
endmodule : canopen_led_props
bind canopen_status_led_driver canopen_led_props #(.MS_CYCLES(MS_CYCLES)) u_props (
    .mclk, .sys_rst, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .led_green, .led_red);

// file: verification/led_watch.sv
`timescale 1ns/10ps
module led_watch (
    input  wire logic        mclk,     // Clock
    input  wire logic        sys_rst,  // Reset, active high
    input  wire logic        clr,      // Restart statistics
    input  wire logic        led,      // Indicator, high lit
    output logic      [63:0] stat_r,   // Lit min, lit max, dark min, dark max
    output logic      [15:0] edges_r   // Level changes since clear
);
    logic        prev_r, seen_r;
    logic [15:0] run_r;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_r <= 1'b0;
            run_r  <= 16'h0000;
        end else begin
            prev_r <= led;
            run_r  <= (led != prev_r) ? 16'h0001 : run_r + 16'h0001;
        end
    end
    // Whole runs after a clear only
    always_ff @(posedge mclk) begin
        if (clr) begin
            seen_r  <= 1'b0;
            edges_r <= 16'h0000;
            stat_r  <= 64'hFFFF_0000_FFFF_0000;
        end else if (led != prev_r) begin
            seen_r  <= 1'b1;
            edges_r <= edges_r + 16'h0001;
            if (seen_r && prev_r && run_r < stat_r[63:48]) stat_r[63:48] <= run_r;
            if (seen_r && prev_r && run_r > stat_r[47:32]) stat_r[47:32] <= run_r;
            if (seen_r && !prev_r && run_r < stat_r[31:16]) stat_r[31:16] <= run_r;
            if (seen_r && !prev_r && run_r > stat_r[15:0]) stat_r[15:0] <= run_r;
        end
    end
endmodule : led_watch

// file: verification/canopen_status_led_driver_bench.sv
`timescale 1ns/10ps
module canopen_status_led_driver_bench;
    localparam int unsigned MSC = 4;
    localparam logic [15:0] ON_C = 16'(canopen_led_pkg::FLASH_ON_MS * MSC);
    localparam logic [15:0] GAP_C = 16'(canopen_led_pkg::GAP_OFF_MS * MSC);
    localparam logic [15:0] BLK_C = 16'(canopen_led_pkg::BLINK_OFF_MS * MSC);
    localparam logic [15:0] LONG_C = 16'(canopen_led_pkg::LONG_OFF_MS * MSC);
    localparam logic [15:0] DARK = 16'h0000;
    localparam logic [15:0] LIT = 16'hFFFF;
    logic        mclk, sys_rst, read, write, clr, waitrequest, led_green, led_red;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, readdata, rd;
    logic [63:0] g_stat, r_stat;
    logic [15:0] g_edges, r_edges;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc = 0;
    canopen_status_led_driver #(.MS_CYCLES(MSC)) i_canopen_status_led_driver (
        .mclk, .sys_rst, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .led_green, .led_red);
    led_watch w_green (.mclk, .sys_rst, .clr, .led(led_green), .stat_r(g_stat),
        .edges_r(g_edges));
    led_watch w_red (.mclk, .sys_rst, .clr, .led(led_red), .stat_r(r_stat),
        .edges_r(r_edges));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task wrap_up;
        $display("Counts: %0d checks, %0d mismatches", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task check(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= !wr;
        write <= wr;
        @(posedge mclk);
        while (waitrequest !== 1'b0 && n < 16) begin
            @(posedge mclk);
            n++;
        end
        rd = readdata;
        check("wait cycles", 32'h1, 32'(n));
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        check(what, exp, rd);
    endtask : rdchk
    task show(input logic [31:0] ctrl, input int n);
        bus(1'b1, 4'h0, 32'h0, 4'hF);
        repeat (4) @(posedge mclk);
        bus(1'b1, 4'h0, ctrl, 4'hF);
        repeat (4) @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask : show
    task chk_led(input logic sel, input logic [15:0] on, offa = DARK, offb = DARK);
        logic [63:0] s;
        s = sel ? r_stat : g_stat;
        if (on == DARK || on == LIT) begin
            check("edges", 32'h0, 32'(sel ? r_edges : g_edges));
            check("level", 32'(on == LIT), 32'(sel ? led_red : led_green));
        end else begin
            check("lit runs", {on, on}, s[63:32]);
            check("dark runs", {offa, offb}, s[31:0]);
        end
    endtask : chk_led
    task t_regs;
        rdchk("ctrl reset", 4'h0, 32'h0);
        rdchk("timebase", 4'hC, 32'(MSC));
        rdchk("unmapped", 4'h2, 32'h0);
        bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
        rdchk("ctrl mask", 4'h0, 32'h0000_0173);
        bus(1'b1, 4'h0, 32'h0, 4'h2);
        bus(1'b1, 4'h4, 32'h0, 4'hF);
        bus(1'b1, 4'h1, 32'h0, 4'hF);
        rdchk("ctrl lanes", 4'h0, 32'h0000_0073);
        rdchk("status", 4'h4, 32'h0000_0210);
        $display("regs done");
    endtask : t_regs
    task t_green;
        show(32'h1, 1000);
        chk_led(1'b0, LIT);
        show(32'h2, 2500);
        chk_led(1'b0, ON_C, BLK_C, BLK_C);
        show(32'h3, 5700);
        chk_led(1'b0, ON_C, LONG_C, LONG_C);
        chk_led(1'b1, DARK);
        $display("green done");
    endtask : t_green
    task t_red;
        show(32'h11, 5700);
        chk_led(1'b1, ON_C, LONG_C, LONG_C);
        chk_led(1'b0, DARK);
        show(32'h31, 7300);
        chk_led(1'b1, ON_C, GAP_C, LONG_C);
        show(32'h73, 1000);
        chk_led(1'b1, LIT);
        chk_led(1'b0, DARK);
        $display("red done");
    endtask : t_red
    task t_dual;
        show(32'h102, 2500);
        chk_led(1'b0, ON_C, BLK_C, BLK_C);
        chk_led(1'b1, DARK);
        show(32'h111, 5700);
        chk_led(1'b0, LIT);
        chk_led(1'b1, ON_C, LONG_C, LONG_C);
        show(32'h100, 1000);
        chk_led(1'b0, DARK);
        show(32'h0, 1000);
        chk_led(1'b0, DARK);
        $display("dual done");
    endtask : t_dual
    task t_restart;
        show(32'h3, 1500);
        bus(1'b1, 4'h0, 32'h2, 4'hF);
        repeat (2) @(posedge mclk);
        check("restart lit", 32'h1, 32'(led_green));
        repeat (900) @(posedge mclk);
        $display("restart done");
    endtask : t_restart
    task t_midreset;
        show(32'h1, 100);
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        check("leds in reset", 32'h0, 32'({led_green, led_red}));
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        rdchk("ctrl after reset", 4'h0, 32'h0);
        $display("mid reset done");
    endtask : t_midreset
    initial begin
        sys_rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        clr = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        byteenable = 4'h0;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_green();
        t_red();
        t_dual();
        t_restart();
        t_midreset();
        wrap_up();
    end
endmodule : canopen_status_led_driver_bench
